// file: sac_adc.sv
// conversion control and serial readout of the sar converter
// How it works
// (R1) rising edge on conversion_start_pin begins a conversion
// (R2) after conversion, start pin low puts result on sdo, back to standby
// (R3) host toggles sclk during standby to shift the result out
// (R4) power-up runs a self-calibration before any conversion
// (R5) recalibrate request at any time runs another self-calibration
// (R6) after power-up the block sits in standby (acquisition)
// (R7) conversion timed by own clock counter, not by sclk
// (R8) result width is a build option of 16, 14 or 12 bits
// (R9) readout carries this very conversion's code, no pipeline delay
// (R10) conversion short enough for 1 Msps fast or 500 kSPS slow variant
// (R11) host link is sclk, sdi and sdo
// (R12) result leaves msb first, one bit per sclk cycle
// (R13) host waits for conversion end and readout before next start
`include "sac_map.svh"
module sac_adc #(
    parameter int RES_BITS = `SAC_RES_BITS
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    // host pins
    input  wire logic        conversion_start_pin_i,
    input  wire logic        sclk_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    // analog front end model: digitised input code
    input  wire logic [15:0] sample_code_i,
    // status
    output logic             standby_o,
    output logic             cal_busy_o,
    output logic             sample_ready_o
);
    // ======================================================
    // local state
    localparam int CONV_CYC = `SAC_CONV_CYC;
    localparam int CAL_CYC  = `SAC_CAL_CYC;
    sac_pkg::sac_phase_t   phase;
    sac_pkg::sac_sample_t  held;
    sac_pkg::sac_sample_t  pop_data;
    logic [7:0]            timer;
    logic                  start_prev;
    logic                  sclk_prev;
    logic [15:0]           sdi_shift;
    logic [15:0]           shreg;
    logic [4:0]            bits_left;
    logic                  push_valid;
    logic                  push_ready;
    logic                  pop_valid;
    logic                  pop_ready;
    logic                  start_rise;
    logic                  start_fall_low;
    logic                  sclk_fall;
    logic                  recal_cmd;
    logic [15:0]           masked_code;
    logic                  recal_pend;

    assign start_rise     = conversion_start_pin_i && !start_prev; // [R1]
    assign start_fall_low = !conversion_start_pin_i;
    assign sclk_fall      = sclk_prev && !sclk_i;
    // recal command word shifted in on sdi; all ones is the chosen code
    assign recal_cmd      = (sdi_shift == 16'hffff); // [R5] [R11]
    // keep only the top RES_BITS of the code, lower bits forced to zero
    assign masked_code = sample_code_i &
        ~(16'hffff >> RES_BITS); // [R8]

    // ======================================================
    // edge history
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_prev <= 1'b0;
            sclk_prev  <= 1'b0;
        end else if (ce_i) begin
            start_prev <= conversion_start_pin_i;
            sclk_prev  <= sclk_i;
        end
    end

    // ======================================================
    // command capture on sdi, sampled on sclk rising edges
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdi_shift <= 16'h0000;
        end else if (ce_i) begin
            if (recal_cmd) begin
                sdi_shift <= 16'h0000;
            end else if (sclk_i && !sclk_prev) begin
                sdi_shift <= {sdi_shift[14:0], sdi_i}; // [R11]
            end
        end
    end

    // ======================================================
    // command met outside standby is kept, not lost with the pattern
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            recal_pend <= 1'b0;
        end else if (ce_i) begin
            if (recal_cmd && phase != sac_pkg::SAC_STANDBY) begin
                recal_pend <= 1'b1; // [R5]
            end else if (phase == sac_pkg::SAC_STANDBY) begin
                recal_pend <= 1'b0;
            end
        end
    end

    // ======================================================
    // phase sequencer; the timer runs on clock_i only
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase <= sac_pkg::SAC_CAL; // [R4]
            timer <= 8'h00;
        end else if (ce_i) begin
            unique case (phase)
                sac_pkg::SAC_CAL: begin
                    if (timer == 8'(CAL_CYC - 1)) begin
                        timer <= 8'h00;
                        phase <= sac_pkg::SAC_STANDBY; // [R6]
                    end else begin
                        timer <= timer + 8'h01;
                    end
                end
                sac_pkg::SAC_STANDBY: begin
                    if (recal_cmd || recal_pend) begin
                        phase <= sac_pkg::SAC_CAL; // [R5]
                    end else if (start_rise) begin
                        phase <= sac_pkg::SAC_CONVERT; // [R1]
                    end
                end
                sac_pkg::SAC_CONVERT: begin
                    // fixed count keeps sclk out of the timing path
                    if (timer == 8'(CONV_CYC - 1)) begin // [R7] [R10]
                        timer <= 8'h00;
                        phase <= sac_pkg::SAC_DONE;
                    end else begin
                        timer <= timer + 8'h01;
                    end
                end
                sac_pkg::SAC_DONE: begin
                    // waits for the host to lower the start pin
                    if (start_fall_low && push_ready) begin
                        phase <= sac_pkg::SAC_STANDBY; // [R2]
                    end
                end
                default: begin
                    timer <= 8'h00;
                    phase <= sac_pkg::SAC_CAL;
                end
            endcase
        end
    end

    assign push_valid = (phase == sac_pkg::SAC_DONE) && start_fall_low;

    // ======================================================
    // result capture on the last conversion cycle
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            held <= '0;
        end else if (ce_i && phase == sac_pkg::SAC_CONVERT &&
                     timer == 8'(CONV_CYC - 1)) begin
            held.code <= masked_code; // [R9]
        end
    end

    // ======================================================
    // result buffer between conversion and serial readout
    sac_fifo #(
        .WIDTH (`SAC_FIFO_WIDTH),
        .DEPTH (`SAC_FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .nrst_i      (nrst_i),
        .ce_i        (ce_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (held),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pop_data)
    );

    // a new word loads only after the previous one is fully out
    assign pop_ready = (bits_left == 5'd0) &&
        (phase == sac_pkg::SAC_STANDBY);

    // ======================================================
    // serial shifter, msb first on sdo
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shreg     <= 16'h0000;
            bits_left <= 5'd0;
            sdo_o     <= `SAC_SDO_RST;
        end else if (ce_i) begin
            if (pop_valid && pop_ready) begin
                shreg     <= {pop_data.code[14:0], 1'b0};
                sdo_o     <= pop_data.code[15]; // [R2] [R12]
                bits_left <= 5'(RES_BITS);
            end else if (sclk_fall && bits_left != 5'd0 &&
                         phase == sac_pkg::SAC_STANDBY) begin // [R3]
                sdo_o     <= shreg[15]; // [R12]
                shreg     <= {shreg[14:0], 1'b0};
                bits_left <= bits_left - 5'd1;
            end
        end
    end

    // ======================================================
    // status outputs
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            standby_o      <= 1'b0;
            cal_busy_o     <= 1'b1;
            sample_ready_o <= 1'b0;
        end else if (ce_i) begin
            standby_o      <= (phase == sac_pkg::SAC_STANDBY); // [R6]
            cal_busy_o     <= (phase == sac_pkg::SAC_CAL);
            sample_ready_o <= (bits_left != 5'd0); // [R13]
        end
    end
endmodule

// file: sac_map.svh
// timing counts and widths for the conversion and readout block
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// ==========================================================
// widths
`define SAC_RES_BITS      16
`define SAC_FIFO_WIDTH    16
`define SAC_FIFO_DEPTH    16
// ==========================================================
// timing (clock 50 MHz, 20 ns)
`define SAC_CLK_NS        20
`define SAC_CONV_NS       500
`define SAC_CONV_CYC      ((`SAC_CONV_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CAL_NS        2000
`define SAC_CAL_CYC       ((`SAC_CAL_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
// ==========================================================
// reset values
`define SAC_SDO_RST       1'b0
`endif

// file: sac_pkg.sv
// types shared by the conversion and readout block
package sac_pkg;
    // ======================================================
    // phase of the converter
    typedef enum logic [2:0] {
        SAC_CAL,
        SAC_STANDBY,
        SAC_CONVERT,
        SAC_DONE
    } sac_phase_t;

    // ======================================================
    // one sample as it travels through the buffer
    typedef struct packed {
        logic [15:0] code;
    } sac_sample_t;
endpackage

// file: sac_fifo.sv
// small flop-based fifo with valid and ready on both sides
module sac_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    input  wire logic             ce_i,
    // write side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // read side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push = ce_i && in_valid_i && in_ready_o;
    assign pop  = ce_i && out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// file: sac_adc_chk.sv
// assertion checker for the conversion and readout block
module sac_adc_chk #(
    parameter int RES_BITS = 16
) (
    // ==========================================================
    // watched ports
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        ce_i,
    input wire logic        conversion_start_pin_i,
    input wire logic        sclk_i,
    input wire logic        sdo_o,
    input wire logic        standby_o,
    input wire logic        cal_busy_o,
    input wire logic        sample_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cal_cnt;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // ==========================================================
    // calibration length, frozen cycles not counted
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cal_cnt <= 8'h00;
        end else if (!cal_busy_o) begin
            cal_cnt <= 8'h00;
        end else if (ce_i) begin
            cal_cnt <= cal_cnt + 8'h01;
        end
    end
    a_cal_at_reset: assert property (
        $rose(nrst_i) |-> cal_busy_o && !standby_o)
        else $error("no calibration after reset");
    a_cal_excl: assert property (
        cal_busy_o && $past(cal_busy_o, 2) |-> !standby_o)
        else $error("standby during calibration");
    a_cal_len: assert property (
        $fell(cal_busy_o) |-> cal_cnt >= 8'h60 && cal_cnt <= 8'h68)
        else $error("calibration length off");
    a_stby_after: assert property (
        $fell(cal_busy_o) |-> ##[0:3] standby_o)
        else $error("no standby after calibration");
    a_conv_start: assert property (
        $rose(conversion_start_pin_i) && standby_o && !cal_busy_o
        |-> ##[1:3] !standby_o)
        else $error("start edge ignored");
    a_conv_hold: assert property (
        $fell(standby_o) && !cal_busy_o |=> !standby_o [*8])
        else $error("conversion too short");
    a_ready_pin: assert property (
        $rose(sample_ready_o) |-> standby_o && !conversion_start_pin_i)
        else $error("result out before pin low");
    // slow sclk: a shift must follow a recent low level
    a_sdo_fall: assert property (
        $changed(sdo_o) && $past(sample_ready_o)
        |-> !$past(sclk_i) || !$past(sclk_i, 2) || !$past(sclk_i, 3))
        else $error("sdo moved without sclk fall");
    c_result: cover property ($rose(sample_ready_o));
    c_recal: cover property ($rose(cal_busy_o) ##1 !standby_o);
    c_cal_end: cover property ($fell(cal_busy_o) ##[1:5] standby_o);
endmodule
bind sac_adc sac_adc_chk #(.RES_BITS(RES_BITS)) sac_adc_chk_inst (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .conversion_start_pin_i(conversion_start_pin_i), .sclk_i(sclk_i),
    .sdo_o(sdo_o), .standby_o(standby_o), .cal_busy_o(cal_busy_o),
    .sample_ready_o(sample_ready_o));

// file: sac_host_model.sv
// host master model driving start pin, sclk and sdi
module sac_host_model (
    // ==========================================================
    // clock, start pin and three-wire link
    input  wire logic clock_i,
    output logic      conversion_start_pin_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        conversion_start_pin_o = 1'b0;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic set_pin(input logic v);
        conversion_start_pin_o = v;
        idle(1);
    endtask
    // levels held several cycles: device samples sclk on its own clock
    task automatic pulse();
        sclk_o = 1'b1;
        idle(3);
        sclk_o = 1'b0;
        idle(4);
    endtask
    task automatic read_word(output logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            w[i] = sdo_i;
            pulse();
        end
    endtask
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            sdi_o = w[i];
            idle(1);
            pulse();
        end
        sdi_o = ~w[0]; // line no longer holds the last bit
    endtask
endmodule

// file: sac_adc_tb_top.sv
// self-checking bench for the conversion and readout block
module sac_adc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i, nrst_i, ce_i, pin, sclk, sdi, sdo;
    logic        standby, cal_busy, ready;
    logic [15:0] code;
    int          n_mismatch = 0;
    int          checks_done = 0;
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    sac_adc sac_adc_inst (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .conversion_start_pin_i(pin), .sclk_i(sclk), .sdi_i(sdi),
        .sdo_o(sdo), .sample_code_i(code), .standby_o(standby),
        .cal_busy_o(cal_busy), .sample_ready_o(ready));
    sac_host_model sac_host_model_inst (.clock_i(clock_i),
        .conversion_start_pin_o(pin), .sclk_o(sclk), .sdi_o(sdi),
        .sdo_i(sdo));
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // bit 0 ready, 1 cal_busy, 2 standby
    task automatic wait_bit(input int b, input logic v, input int lim);
        logic [2:0] st;
        for (int k = 0; k < lim; k++) begin
            st = {standby, cal_busy, ready};
            if (st[b] === v)
                return;
            @(negedge clock_i);
        end
        chk("wait", {15'h0, v}, {15'h0, st[b]});
        wrap_up();
    endtask
    task automatic t_powerup();
        chk("cal_busy", 16'h1, {15'h0, cal_busy});
        sac_host_model_inst.set_pin(1'b1);
        wait_bit(1, 1'b0, 200);
        sac_host_model_inst.set_pin(1'b0);
        wait_bit(2, 1'b1, 8);
        repeat (30) @(negedge clock_i);
        chk("standby", 16'h1, {15'h0, standby});
        chk("no_conv", 16'h0, {15'h0, ready});
        $display("t_powerup done");
    endtask
    // late change of the analog code must not reach the result
    task automatic t_convert(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] w;
        code = a;
        sac_host_model_inst.set_pin(1'b1);
        repeat (2) @(negedge clock_i);
        chk("busy", 16'h0, {15'h0, standby});
        sac_host_model_inst.pulse();
        repeat (20) @(negedge clock_i);
        code = b;
        sac_host_model_inst.set_pin(1'b0);
        wait_bit(0, 1'b1, 10);
        chk("stby", 16'h1, {15'h0, standby});
        sac_host_model_inst.read_word(w);
        chk("word", a, w);
        chk("left", 16'h0, {15'h0, ready});
        $display("t_convert %h done", a);
    endtask
    task automatic t_recal();
        sac_host_model_inst.send_word(16'hffff);
        wait_bit(1, 1'b1, 20);
        repeat (2) @(negedge clock_i);
        chk("recal", 16'h0, {15'h0, standby});
        sac_host_model_inst.set_pin(1'b1);
        wait_bit(1, 1'b0, 120);
        sac_host_model_inst.set_pin(1'b0);
        wait_bit(2, 1'b1, 8);
        chk("no_conv", 16'h0, {15'h0, ready});
        $display("t_recal done");
    endtask
    // clock enable low freezes the conversion timer and the buffer
    task automatic t_freeze(input logic [15:0] a);
        logic [15:0] w;
        code = a;
        sac_host_model_inst.set_pin(1'b1);
        sac_host_model_inst.set_pin(1'b0);
        ce_i = 1'b0;
        repeat (40) @(negedge clock_i);
        chk("frz_stby", 16'h0, {15'h0, standby});
        chk("frz_rdy", 16'h0, {15'h0, ready});
        ce_i = 1'b1;
        wait_bit(0, 1'b1, 40);
        chk("frz_stby2", 16'h1, {15'h0, standby});
        sac_host_model_inst.read_word(w);
        chk("frz_word", a, w);
        $display("t_freeze done");
    endtask
    // reset in mid conversion: calibration again, nothing left to read
    task automatic t_reset();
        sac_host_model_inst.set_pin(1'b1);
        repeat (5) @(negedge clock_i);
        nrst_i = 1'b0;
        sac_host_model_inst.set_pin(1'b0);
        repeat (5) @(negedge clock_i);
        chk("rst_cal", 16'h1, {15'h0, cal_busy});
        chk("rst_stby", 16'h0, {15'h0, standby});
        chk("rst_rdy", 16'h0, {15'h0, ready});
        nrst_i = 1'b1;
        wait_bit(1, 1'b0, 200);
        wait_bit(2, 1'b1, 8);
        repeat (30) @(negedge clock_i);
        chk("rst_idle", 16'h0, {15'h0, ready});
        $display("t_reset done");
    endtask
    initial begin
        logic [15:0] tbl [5] = '{16'h8001, 16'h7ffe, 16'hffff, 16'h0000,
                                 16'ha5c3};
        nrst_i = 1'b0;
        ce_i = 1'b1;
        code = 16'h0000;
        repeat (6) @(negedge clock_i);
        nrst_i = 1'b1;
        t_powerup();
        foreach (tbl[i])
            t_convert(tbl[i], ~tbl[i]);
        t_freeze(16'h5a3c);
        t_recal();
        t_reset();
        t_convert(16'h1234, 16'h4321);
        wrap_up();
    end
endmodule
